// ==== common/mad_cfg.svh ====
// Constants for the address mark detector: pattern, widths, reset values.
// Assumes inclusion by bare name from design files.
`ifndef MAD_CFG_SVH
`define MAD_CFG_SVH

// ==========================================================
// Shift registers and pattern
`define MAD_SR_WIDTH      8
`define MAD_DATA_PATTERN  8'ha1
`define MAD_CLOCK_PATTERN 8'h0a

// ==========================================================
// Reset values and buffer depth
`define MAD_SR_RESET      8'h00
`define MAD_BUF_DEPTH     2

`endif

// ==== common/mad_pkg.sv ====
// Types shared by the address mark detector files.
// Assumes mad_cfg.svh is on the include path.
package mad_pkg;

  // ==========================================================
  // Separated bit pair sampled from the data separator
  typedef struct packed {
    logic data;
    logic clock;
  } mad_pair_t;

  // ==========================================================
  // Output serialiser states
  typedef enum logic [1:0] {
    MAD_IDLE = 2'b00,
    MAD_LOW  = 2'b01,
    MAD_HIGH = 2'b10
  } mad_drain_t;

endpackage

// ==== logic/mad_bit_buf.sv ====
// Two-entry valid/ready buffer for the recovered data stream.
// Assumes one clock, asynchronous active-low reset, synchronous flush.
`timescale 1ns/1ps

module mad_bit_buf #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);

  // ==========================================================
  // Parameter check
  initial begin
    if (DEPTH != 2 || WIDTH < 1) begin
      $error("mad_bit_buf serves only DEPTH 2 and WIDTH >= 1");
    end
  end

  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0]       count;

  // ==========================================================
  // Handshake decode
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = slot0;

  // Slot 0 is the head; slot 1 holds the second word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0 <= '0;
      slot1 <= '0;
      count <= 2'd0;
    end else if (flush) begin
      count <= 2'd0;
    end else begin
      if (pop && count == 2'd2) begin
        slot0 <= slot1;
      end
      if (push && (count == 2'd0 || (count == 2'd1 && pop))) begin
        slot0 <= in_data;
      end
      if (push && count == 2'd1 && !pop) begin
        slot1 <= in_data;
      end
      if (push && count == 2'd2 && pop) begin
        slot1 <= in_data;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// ==== logic/mad_detector.sv ====
// MFM address mark detector with recovered data output and spare flop.
// Assumes all inputs synchronous to REF_CLK (50 MHz); read clock
// phases are sampled and their falling edges found here.
`timescale 1ns/1ps
`include "mad_cfg.svh"

// Contract
// - Enable low inhibits shifting; detect, bit clock, serial data inactive.
// - Data bit shifts in on each falling edge of the read clock; none while a full buffer stalls after detection.
// - Clock bit shifts in on each falling edge of the complementary phase; none while a full buffer stalls after detection.
// - Serial data comes from the data register's final stage, seven bits late.
// - After each shift compare both registers for data A1, clock 0A.
// - On match drive mark found high and its complement low.
// - Detect outputs stay latched until detection enable goes low.
// - Bit clock toggles after detection, inactive while enable is low.
// - Serial data changes with the output bit clock low, one cycle before each bit clock pulse.
// - Rising edge on the spare flop clock sets its output to zero.
// - Low on the spare flop clear forces its output to one at once.
// - Low pulses on test outputs when data holds A1 or clock holds 0A.
module mad_detector
  import mad_pkg::*;
#(
  parameter int SR_WIDTH = `MAD_SR_WIDTH
) (
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  input  wire logic              DETECTION_ENABLE,
  input  wire logic              READ_CLK,
  input  wire logic              READ_CLK_N,
  input  wire mad_pkg::mad_pair_t LINE_IN,
  output      logic              SERIAL_DATA_OUT,
  output      logic              OUTPUT_BIT_CLOCK,
  input  wire logic              OUT_READY,
  output      logic              SHIFT_READY,
  output      logic              MARK_FOUND,
  output      logic              MARK_FOUND_N,
  output      logic              DATA_BYTE_MATCH_PULSE_N,
  output      logic              CLOCK_BYTE_MATCH_PULSE_N,
  input  wire logic              AUX_FLOP_CLOCK,
  input  wire logic              AUX_FLOP_CLEAR_N,
  output      logic              AUX_FLOP_OUT
);

  // ==========================================================
  // Parameter check
  initial begin
    if (SR_WIDTH != 8) begin
      $error("mad_detector compares eight-bit registers only");
    end
  end

  logic [SR_WIDTH-1:0] data_sr;
  logic [SR_WIDTH-1:0] clock_sr;
  logic                read_clk_q;
  logic                read_clk_n_q;
  logic                found;
  logic                data_pulse;
  logic                clock_pulse;
  logic                aux_clk_q;
  logic                aux_state;
  logic                serial_out;
  logic                bit_clock;
  mad_drain_t          drain;
  mad_drain_t          next_drain;

  // ==========================================================
  // Edge detection on the sampled read clock phases
  wire enabled   = DETECTION_ENABLE;
  wire data_fall = read_clk_q && !READ_CLK;
  wire clk_fall  = read_clk_n_q && !READ_CLK_N;

  // Buffer handshake: a full buffer after detection stalls shifting
  wire buf_in_ready;
  wire buf_out_valid;
  wire buf_out_data;
  wire stall      = found && !buf_in_ready;
  wire data_shift = enabled && data_fall && !stall;
  wire clk_shift  = enabled && clk_fall && !stall;

  // ==========================================================
  // Next register contents and 16-bit comparison on them
  wire [SR_WIDTH-1:0] next_data_sr  = data_shift ?
    {data_sr[SR_WIDTH-2:0], LINE_IN.data} : data_sr;
  wire [SR_WIDTH-1:0] next_clock_sr = clk_shift ?
    {clock_sr[SR_WIDTH-2:0], LINE_IN.clock} : clock_sr;
  wire data_hit  = (next_data_sr == `MAD_DATA_PATTERN);
  wire clock_hit = (next_clock_sr == `MAD_CLOCK_PATTERN);
  wire any_shift = data_shift || clk_shift;
  wire match     = any_shift && data_hit && clock_hit;

  // Bits entering the data register's last stage after detection
  wire push_bit   = found && data_shift;
  wire drain_take = (drain == MAD_IDLE) && OUT_READY && buf_out_valid;

  // Host-visible stall indicator
  assign SHIFT_READY = !stall;

  // Phase history for edge detection
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      read_clk_q   <= 1'b0;
      read_clk_n_q <= 1'b0;
    end else begin
      read_clk_q   <= READ_CLK;
      read_clk_n_q <= READ_CLK_N;
    end
  end

  // Shift registers; cleared while detection is disabled
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_sr  <= `MAD_SR_RESET;
      clock_sr <= `MAD_SR_RESET;
    end else if (!enabled) begin
      data_sr  <= `MAD_SR_RESET;
      clock_sr <= `MAD_SR_RESET;
    end else begin
      data_sr  <= next_data_sr;
      clock_sr <= next_clock_sr;
    end
  end

  // Latched detect flag
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      found <= 1'b0;
    end else if (!enabled) begin
      found <= 1'b0;
    end else if (match) begin
      found <= 1'b1;
    end
  end

  // Test pulses: one REF_CLK cycle per matching shift
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_pulse  <= 1'b0;
      clock_pulse <= 1'b0;
    end else begin
      data_pulse  <= enabled && data_shift && data_hit;
      clock_pulse <= enabled && clk_shift && clock_hit;
    end
  end

  // ==========================================================
  // Two-entry buffer between the shift register and the serialiser
  mad_bit_buf #(
    .WIDTH (1),
    .DEPTH (`MAD_BUF_DEPTH)
  ) u_buf (
    .clk       (REF_CLK),
    .rst_n     (ARST_N),
    .flush     (!enabled),
    .in_valid  (push_bit),
    .in_ready  (buf_in_ready),
    .in_data   (next_data_sr[SR_WIDTH-1]),
    .out_valid (buf_out_valid),
    .out_ready (drain_take),
    .out_data  (buf_out_data)
  );

  // ==========================================================
  // Serialiser: data set with clock low, clock high next cycle
  always_comb begin
    next_drain = drain;
    unique case (drain)
      MAD_IDLE: begin
        if (drain_take) begin
          next_drain = MAD_LOW;
        end
      end
      MAD_LOW:  next_drain = MAD_HIGH;
      MAD_HIGH: next_drain = MAD_IDLE;
      default:  next_drain = MAD_IDLE;
    endcase
  end

  // Output bit and bit clock registers
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      drain      <= MAD_IDLE;
      serial_out <= 1'b0;
      bit_clock  <= 1'b0;
    end else if (!enabled) begin
      drain      <= MAD_IDLE;
      serial_out <= 1'b0;
      bit_clock  <= 1'b0;
    end else begin
      drain      <= next_drain;
      if (drain_take) begin
        serial_out <= buf_out_data;
      end
      bit_clock  <= (next_drain == MAD_HIGH);
    end
  end

  // ==========================================================
  // Spare flop: rising clock edge sets 0, low clear forces 1
  wire aux_rise = AUX_FLOP_CLOCK && !aux_clk_q;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aux_clk_q <= 1'b0;
      aux_state <= 1'b1;
    end else begin
      aux_clk_q <= AUX_FLOP_CLOCK;
      if (!AUX_FLOP_CLEAR_N) begin
        aux_state <= 1'b1;
      end else if (aux_rise) begin
        aux_state <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Output assignments
  assign SERIAL_DATA_OUT          = serial_out;
  assign OUTPUT_BIT_CLOCK         = bit_clock;
  assign MARK_FOUND               = found;
  assign MARK_FOUND_N             = !found;
  assign DATA_BYTE_MATCH_PULSE_N  = !data_pulse;
  assign CLOCK_BYTE_MATCH_PULSE_N = !clock_pulse;
  assign AUX_FLOP_OUT             = aux_state || !AUX_FLOP_CLEAR_N;

endmodule

// ==== tb/mad_detector_chk.sv ====
// Port assertions for the address mark detector.
// Assumes one REF_CLK domain; bound onto mad_detector.
`timescale 1ns/1ps
// ============
// Checker
module mad_detector_chk (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic DETECTION_ENABLE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic OUTPUT_BIT_CLOCK,
  input wire logic MARK_FOUND,
  input wire logic MARK_FOUND_N,
  input wire logic DATA_BYTE_MATCH_PULSE_N,
  input wire logic CLOCK_BYTE_MATCH_PULSE_N,
  input wire logic AUX_FLOP_CLOCK,
  input wire logic AUX_FLOP_CLEAR_N,
  input wire logic AUX_FLOP_OUT
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Output bit taken, and a clean spare clock rise
  sequence s_take;
    DETECTION_ENABLE && MARK_FOUND && $changed(SERIAL_DATA_OUT);
  endsequence
  sequence s_aux_rise;
    $rose(AUX_FLOP_CLOCK) && AUX_FLOP_CLEAR_N ##1 AUX_FLOP_CLEAR_N[*2];
  endsequence
  // Properties on the detector outputs
  property p_dis;
    !DETECTION_ENABLE |=> !MARK_FOUND && !OUTPUT_BIT_CLOCK
      && !SERIAL_DATA_OUT;
  endproperty
  a_dis: assert property (p_dis) else $error("not idle");
  property p_comp; MARK_FOUND_N != MARK_FOUND; endproperty
  a_comp: assert property (p_comp) else $error("pair");
  property p_latch; MARK_FOUND && DETECTION_ENABLE |=> MARK_FOUND; endproperty
  a_latch: assert property (p_latch) else $error("unlatched");
  // The completing shift may be a data shift or a clock-only shift
  property p_mark; $rose(MARK_FOUND) |-> !DATA_BYTE_MATCH_PULSE_N
    || !CLOCK_BYTE_MATCH_PULSE_N; endproperty
  a_mark: assert property (p_mark) else $error("no pulse");
  // Test pulses last a single cycle
  property p_dpulse;
    !DATA_BYTE_MATCH_PULSE_N |=> DATA_BYTE_MATCH_PULSE_N;
  endproperty
  a_dpulse: assert property (p_dpulse) else $error("data pulse");
  property p_cpulse;
    !CLOCK_BYTE_MATCH_PULSE_N |=> CLOCK_BYTE_MATCH_PULSE_N;
  endproperty
  a_cpulse: assert property (p_cpulse) else $error("clock pulse");
  property p_bclk; OUTPUT_BIT_CLOCK |-> MARK_FOUND ##1 !OUTPUT_BIT_CLOCK;
  endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock");
  property p_take; s_take |=> OUTPUT_BIT_CLOCK; endproperty
  a_take: assert property (p_take) else $error("no bit clock");
  property p_clr; !AUX_FLOP_CLEAR_N |-> AUX_FLOP_OUT; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_set; s_aux_rise |-> !AUX_FLOP_OUT; endproperty
  a_set: assert property (p_set) else $error("set");
endmodule
bind mad_detector mad_detector_chk mad_detector_chk_inst (
  .REF_CLK, .ARST_N, .DETECTION_ENABLE, .SERIAL_DATA_OUT,
  .OUTPUT_BIT_CLOCK, .MARK_FOUND, .MARK_FOUND_N, .DATA_BYTE_MATCH_PULSE_N,
  .CLOCK_BYTE_MATCH_PULSE_N,
  .AUX_FLOP_CLOCK, .AUX_FLOP_CLEAR_N, .AUX_FLOP_OUT);

// ==== tb/mad_detector_test.sv ====
// Self-checking bench for the address mark detector.
// Assumes the partner model drives the read side.
`timescale 1ns/1ps
// ============
// Bench
module mad_detector_test;
  import mad_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b0;
  logic        ordy = 1'b1;
  logic        aclk = 1'b0;
  logic        aclr_n = 1'b1;
  logic        rc, rc_n, sdo, bclk, srdy, mk, mk_n, pd, pc, aq;
  logic [7:0]  rx, rxc, n0;
  int          pd_cnt = 0;
  int          pc_cnt = 0;
  int          d0, c0;
  mad_pair_t   ln;
  int          err_total = 0;
  int          check_count = 0;
  // Rows: expected mark, data byte, clock byte
  logic [16:0] rows [5] = '{17'h1a10a, 17'h0a10b, 17'h0a00a,
                            17'h0a100, 17'h0210a};
  mad_detector mad_detector_inst (
    .REF_CLK(clk), .ARST_N(rst_n), .DETECTION_ENABLE(en),
    .READ_CLK(rc), .READ_CLK_N(rc_n), .LINE_IN(ln),
    .SERIAL_DATA_OUT(sdo), .OUTPUT_BIT_CLOCK(bclk), .OUT_READY(ordy),
    .SHIFT_READY(srdy), .MARK_FOUND(mk), .MARK_FOUND_N(mk_n),
    .DATA_BYTE_MATCH_PULSE_N(pd), .CLOCK_BYTE_MATCH_PULSE_N(pc),
    .AUX_FLOP_CLOCK(aclk), .AUX_FLOP_CLEAR_N(aclr_n), .AUX_FLOP_OUT(aq));
  mad_sep_model mad_sep_model_inst (
    .clk(clk), .shift_ready(srdy), .bit_clock(bclk), .serial_in(sdo),
    .read_clk(rc), .read_clk_n(rc_n), .line(ln), .rx(rx), .rx_cnt(rxc));
  // Clock
  always #10 clk = ~clk;
  // Count cycles with a test pulse low
  always @(posedge clk) begin
    if (pd === 1'b0) pd_cnt <= pd_cnt + 1;
    if (pc === 1'b0) pc_cnt <= pc_cnt + 1;
  end
  // Compares and helpers
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic send_byte(input logic [7:0] d, input logic [7:0] c);
    for (int b = 7; b >= 0; b--) mad_sep_model_inst.send(d[b], c[b]);
  endtask
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      en <= 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(mk, 1'b0);
      chk_bit(bclk, 1'b0);
      @(posedge clk);
      en <= 1'b1;
      d0 = pd_cnt;
      c0 = pc_cnt;
      send_byte(rows[i][15:8], rows[i][7:0]);
      @(negedge clk);
      chk_bit(mk, rows[i][16]);
      chk_bit(mk_n, !rows[i][16]);
      chk_bit(pd_cnt == d0 + 1, rows[i][15:8] == 8'ha1);
      chk_bit(pc_cnt == c0 + 1, rows[i][7:0] == 8'h0a);
    end
    // Mark, then a byte out with the receiver stalled
    @(posedge clk);
    send_byte(8'ha1, 8'h0a);
    n0 = rxc;
    ordy <= 1'b0;
    fork
      send_byte(8'h3c, 8'h00);
      begin
        repeat (30) @(negedge clk);
        chk_bit(srdy, 1'b0);
        @(posedge clk);
        ordy <= 1'b1;
      end
    join
    for (int k = 0; k < 100 && rxc !== n0 + 8'h08; k++) @(posedge clk);
    chk_byte(rx, 8'h42);
    chk_byte(rxc - n0, 8'h08);
    // Spare flop: clear, rise, clear while clock stays high
    @(posedge clk);
    aclr_n <= 1'b0;
    @(negedge clk);
    chk_bit(aq, 1'b1);
    @(posedge clk);
    aclr_n <= 1'b1;
    aclk <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(aq, 1'b0);
    @(posedge clk);
    aclr_n <= 1'b0;
    @(negedge clk);
    chk_bit(aq, 1'b1);
    @(posedge clk);
    aclr_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(aq, 1'b1);
    // Mid-run reset with the mark latched and the spare flop set
    chk_bit(mk, 1'b1);
    @(posedge clk);
    aclk <= 1'b0;
    @(posedge clk);
    aclk <= 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(aq, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk_bit(mk, 1'b0);
    chk_bit(mk_n, 1'b1);
    chk_bit(aq, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    aclk <= 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(mk, 1'b0);
    chk_bit(srdy, 1'b1);
    chk_bit(pd, 1'b1);
    chk_bit(bclk, 1'b0);
    finish_test();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule

// ==== tb/mad_sep_model.sv ====
// Separator and bit receiver model for the detector.
// Assumes send is called at a clk rising edge.
`timescale 1ns/1ps
// ============
// Partner
module mad_sep_model (
  input  wire logic          clk,
  input  wire logic          shift_ready,
  input  wire logic          bit_clock,
  input  wire logic          serial_in,
  output      logic          read_clk,
  output      logic          read_clk_n,
  output mad_pkg::mad_pair_t line,
  output      logic [7:0]    rx,
  output      logic [7:0]    rx_cnt
);
  import mad_pkg::*;
  // Idle: read clock low, its phase high
  initial begin
    read_clk = 1'b0;
    read_clk_n = 1'b1;
    line = '0;
    rx = 8'h00;
    rx_cnt = 8'h00;
  end
  // One bit: clock phase falls first, then data phase
  task automatic send(input logic d, input logic c);
    for (int n = 0; n < 200 && shift_ready !== 1'b1; n++) @(posedge clk);
    line <= '{data: d, clock: c};
    read_clk <= 1'b1;
    read_clk_n <= 1'b0;
    repeat (2) @(posedge clk);
    read_clk <= 1'b0;
    read_clk_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Take one bit per bit clock pulse
  always @(posedge clk) begin
    if (bit_clock === 1'b1) begin
      rx <= {rx[6:0], serial_in};
      rx_cnt <= rx_cnt + 8'h01;
    end
  end
endmodule
